// >>> i2c_flags_pkg.sv
package i2c_flags_pkg;

    // register offsets on the plain register port
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_PRIM_ADDR = 8'h01;
    localparam logic [7:0] OFS_SEC_ADDR = 8'h02;
    localparam logic [7:0] OFS_CTRL = 8'h03;
    localparam logic [7:0] OFS_DATA = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h05;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h06;

    // status flag positions
    localparam int BIT_SECOND = 4;
    localparam int BIT_ARB = 3;
    localparam int BIT_SLAVE = 2;
    localparam int BIT_GCALL = 1;
    localparam logic [7:0] FLAG_MASK = 8'h1e;
    localparam logic [7:0] DATA_CLR_MASK = 8'h0e;
    localparam logic [7:0] START_CLR_MASK = 8'h10;

    // address registers: address in [7:1], format select in [0]
    localparam int ADDR_FS_BIT = 0;

    // control register bits
    localparam int CTRL_MASTER = 0;
    localparam int CTRL_TRANSMIT = 1;
    localparam int CTRL_ARB_LOST_SELECT = 2;
    localparam int CTRL_START = 3;

    // reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [7:0] MASK_RESET = 8'h00;

    // bus frame figures
    localparam logic [7:0] GCALL_VALUE = 8'h00;
    localparam logic [3:0] BYTE_LAST = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;

    typedef struct packed {
        logic       scl_s1;
        logic       scl_s2;
        logic       scl_s3;
        logic       sda_s1;
        logic       sda_s2;
        logic       sda_s3;
        logic [7:0] shift;
        logic [3:0] cnt;
        logic       first;
    } mon_state_t;

    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] arm;
        logic [7:0] prim_addr;
        logic [7:0] sec_addr;
        logic [2:0] ctrl;
        logic [7:0] tx_data;
        logic [7:0] rx_data;
        logic [7:0] irq_stat;
        logic [7:0] irq_mask;
        logic [7:0] rdata;
        logic       irq;
        logic       start_wait;
    } core_state_t;

endpackage

// >>> i2c_mon_if.sv
`timescale 1ns/1ps
interface i2c_mon_if;
    logic       scl_rise;
    logic       scl_fall;
    logic       sda_fall;
    logic       sda_lvl;
    logic       start_det;
    logic       byte_done;
    logic       byte_first;
    logic [7:0] byte_val;

    modport mon (
        output scl_rise, scl_fall, sda_fall, sda_lvl,
        output start_det, byte_done, byte_first, byte_val
    );
    modport core (
        input scl_rise, scl_fall, sda_fall, sda_lvl,
        input start_det, byte_done, byte_first, byte_val
    );
endinterface

// >>> i2c_bus_monitor.sv
`timescale 1ns/1ps
module i2c_bus_monitor (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // bus pins
    input wire logic scl_pin_i,
    input wire logic sda_pin_i,
    // bus events
    i2c_mon_if.mon mon
);

    i2c_flags_pkg::mon_state_t q;
    i2c_flags_pkg::mon_state_t n;

    // edges use only the second and third stages
    assign mon.scl_rise = q.scl_s2 && !q.scl_s3;
    assign mon.scl_fall = !q.scl_s2 && q.scl_s3;
    assign mon.sda_fall = !q.sda_s2 && q.sda_s3;
    assign mon.sda_lvl = q.sda_s2;
    assign mon.start_det = q.scl_s2 && q.scl_s3 && !q.sda_s2 && q.sda_s3;
    assign mon.byte_done = mon.scl_rise && !mon.start_det
                           && (q.cnt == i2c_flags_pkg::BYTE_LAST);
    assign mon.byte_first = q.first;
    assign mon.byte_val = {q.shift[6:0], q.sda_s2};

    always_comb begin
        n = q;
        n.scl_s1 = scl_pin_i;
        n.scl_s2 = q.scl_s1;
        n.scl_s3 = q.scl_s2;
        n.sda_s1 = sda_pin_i;
        n.sda_s2 = q.sda_s1;
        n.sda_s3 = q.sda_s2;
        if (mon.start_det) begin
            n.cnt = 4'h0;
            n.first = 1'b1;
        end else if (q.scl_s2 && q.scl_s3 && q.sda_s2 && !q.sda_s3) begin
            // stop condition ends the frame
            n.cnt = 4'h0;
            n.first = 1'b0;
        end else if (mon.scl_rise) begin
            if (q.cnt == i2c_flags_pkg::ACK_SLOT) begin
                n.cnt = 4'h0;
                n.first = 1'b0;
            end else begin
                n.shift = mon.byte_val;
                n.cnt = q.cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

endmodule

// >>> i2c_addr_match_arb_flags.sv
`timescale 1ns/1ps
module i2c_addr_match_arb_flags (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    // internal line levels from the transfer engine
    input wire logic int_sda_i,
    input wire logic int_scl_i,
    // status and interrupt
    output logic [7:0] status_flags_o,
    output logic irq_o
);

    i2c_flags_pkg::core_state_t q;
    i2c_flags_pkg::core_state_t n;

    i2c_mon_if mon_bus ();

    i2c_bus_monitor u_mon (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .scl_pin_i(scl_i),
        .sda_pin_i(sda_i),
        .mon(mon_bus)
    );

    logic mtx_w;
    logic srx_w;
    logic rd_stat_w;
    logic wr_stat_w;
    logic wr_ctrl_w;
    logic data_clr_w;
    logic first_w;
    logic gc_w;
    logic sec_set_w;
    logic arb_set_w;
    logic slv_set_w;
    logic gc_set_w;
    logic [7:0] set_w;
    logic [7:0] clr_w;

    assign mtx_w = q.ctrl[i2c_flags_pkg::CTRL_MASTER] && q.ctrl[i2c_flags_pkg::CTRL_TRANSMIT];
    assign srx_w = !q.ctrl[i2c_flags_pkg::CTRL_MASTER]
                   && !q.ctrl[i2c_flags_pkg::CTRL_TRANSMIT];
    assign rd_stat_w = rd_i && (addr_i == i2c_flags_pkg::OFS_STATUS);
    assign wr_stat_w = wr_i && (addr_i == i2c_flags_pkg::OFS_STATUS);
    assign wr_ctrl_w = wr_i && (addr_i == i2c_flags_pkg::OFS_CTRL);
    // a data write in transmit or a data read in receive clears the slave match, general call and arbitration flags
    assign data_clr_w = (wr_i && (addr_i == i2c_flags_pkg::OFS_DATA)
                         && q.ctrl[i2c_flags_pkg::CTRL_TRANSMIT])
                        || (rd_i && (addr_i == i2c_flags_pkg::OFS_DATA)
                         && !q.ctrl[i2c_flags_pkg::CTRL_TRANSMIT]);

    // first frame after start, seen in slave receive
    assign first_w = mon_bus.byte_done && mon_bus.byte_first && srx_w;
    assign gc_w = (mon_bus.byte_val == i2c_flags_pkg::GCALL_VALUE);

    assign sec_set_w = first_w
                       && (mon_bus.byte_val[7:1] == q.sec_addr[7:1])
                       && !q.sec_addr[i2c_flags_pkg::ADDR_FS_BIT];
    // general call with primary select 1 never reaches slave match
    assign slv_set_w = first_w && !q.prim_addr[i2c_flags_pkg::ADDR_FS_BIT]
                       && ((mon_bus.byte_val[7:1] == q.prim_addr[7:1]) || gc_w);
    assign gc_set_w = first_w && gc_w
                      && (!q.prim_addr[i2c_flags_pkg::ADDR_FS_BIT]
                          || !q.sec_addr[i2c_flags_pkg::ADDR_FS_BIT]);
    assign arb_set_w = (mtx_w && mon_bus.scl_rise && (int_sda_i != mon_bus.sda_lvl))
                       || (mtx_w && !q.ctrl[i2c_flags_pkg::CTRL_ARB_LOST_SELECT]
                           && mon_bus.scl_fall && int_scl_i)
                       || (q.start_wait && q.ctrl[i2c_flags_pkg::CTRL_ARB_LOST_SELECT]
                           && mon_bus.sda_fall && int_sda_i);

    assign set_w = {3'h0, sec_set_w, arb_set_w, slv_set_w, gc_set_w, 1'b0};

    // a write of 0 clears only bits that were read as 1; writing 1 does nothing
    assign clr_w = ((mon_bus.start_det ? i2c_flags_pkg::START_CLR_MASK : 8'h00)
                    | (data_clr_w ? i2c_flags_pkg::DATA_CLR_MASK : 8'h00)
                    | (wr_stat_w ? (q.arm & ~wdata_i) : 8'h00))
                   & i2c_flags_pkg::FLAG_MASK;

    always_comb begin
        n = q;
        // set wins over a clear in the same cycle
        n.flags = ((q.flags & ~clr_w) | set_w) & i2c_flags_pkg::FLAG_MASK;
        n.arm = (rd_stat_w ? q.flags : q.arm) & n.flags;
        n.irq_stat = ((q.irq_stat & ~(wr_i && addr_i == i2c_flags_pkg::OFS_IRQ_STAT
                                      ? wdata_i : 8'h00)) | set_w)
                     & i2c_flags_pkg::FLAG_MASK;
        if (wr_i) begin
            case (addr_i)
                i2c_flags_pkg::OFS_PRIM_ADDR: n.prim_addr = wdata_i;
                i2c_flags_pkg::OFS_SEC_ADDR: n.sec_addr = wdata_i;
                i2c_flags_pkg::OFS_CTRL: n.ctrl = wdata_i[2:0];
                i2c_flags_pkg::OFS_DATA: n.tx_data = wdata_i;
                i2c_flags_pkg::OFS_IRQ_MASK: n.irq_mask = wdata_i & i2c_flags_pkg::FLAG_MASK;
                default: n.ctrl = q.ctrl;
            endcase
        end
        if (mon_bus.byte_done) begin
            n.rx_data = mon_bus.byte_val;
        end
        // start command arms the early-SDA check until we drive SDA low, arbitration is lost or master transmit ends
        if (wr_ctrl_w && wdata_i[i2c_flags_pkg::CTRL_START]
                && wdata_i[i2c_flags_pkg::CTRL_MASTER]
                && wdata_i[i2c_flags_pkg::CTRL_TRANSMIT]) begin
            n.start_wait = 1'b1;
        end else if (!int_sda_i || arb_set_w || !mtx_w) begin
            n.start_wait = 1'b0;
        end
        n.rdata = 8'h00;
        if (rd_i) begin
            case (addr_i)
                i2c_flags_pkg::OFS_STATUS: n.rdata = q.flags;
                i2c_flags_pkg::OFS_PRIM_ADDR: n.rdata = q.prim_addr;
                i2c_flags_pkg::OFS_SEC_ADDR: n.rdata = q.sec_addr;
                i2c_flags_pkg::OFS_CTRL: n.rdata = {5'h00, q.ctrl};
                i2c_flags_pkg::OFS_DATA: n.rdata = q.rx_data;
                i2c_flags_pkg::OFS_IRQ_STAT: n.rdata = q.irq_stat;
                i2c_flags_pkg::OFS_IRQ_MASK: n.rdata = q.irq_mask;
                default: n.rdata = 8'h00;
            endcase
        end
        n.irq = |(n.irq_stat & n.irq_mask);
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            q.flags <= i2c_flags_pkg::STATUS_RESET;
            q.arm <= i2c_flags_pkg::STATUS_RESET;
            q.prim_addr <= i2c_flags_pkg::ADDR_RESET;
            q.sec_addr <= i2c_flags_pkg::ADDR_RESET;
            q.ctrl <= i2c_flags_pkg::CTRL_RESET;
            q.tx_data <= 8'h00;
            q.rx_data <= 8'h00;
            q.irq_stat <= i2c_flags_pkg::STATUS_RESET;
            q.irq_mask <= i2c_flags_pkg::MASK_RESET;
            q.rdata <= 8'h00;
            q.irq <= 1'b0;
            q.start_wait <= 1'b0;
        end else begin
            q <= n;
        end
    end

    assign rdata_o = q.rdata;
    assign status_flags_o = q.flags;
    assign irq_o = q.irq;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);

    property p_unused_bits_zero;
        (q.flags & ~i2c_flags_pkg::FLAG_MASK) == 8'h00;
    endproperty
    a_unused_bits_zero: assert property (p_unused_bits_zero)
        else $error("status bits outside the flag set are not zero");

    property p_second_match;
        first_w && (mon_bus.byte_val[7:1] == q.sec_addr[7:1]) && !q.sec_addr[0]
            |=> status_flags_o[4];
    endproperty
    a_second_match: assert property (p_second_match)
        else $error("second address match did not set its flag");

    property p_start_clears_second;
        mon_bus.start_det && !sec_set_w |=> !status_flags_o[4];
    endproperty
    a_start_clears_second: assert property (p_start_clears_second)
        else $error("start condition did not clear second match flag");

    property p_sda_mismatch;
        mtx_w && mon_bus.scl_rise && (int_sda_i != mon_bus.sda_lvl) |=> status_flags_o[3];
    endproperty
    a_sda_mismatch: assert property (p_sda_mismatch)
        else $error("sda mismatch at scl rise did not flag arbitration lost");

    property p_scl_fall_high;
        mtx_w && !q.ctrl[2] && mon_bus.scl_fall && int_scl_i |=> status_flags_o[3];
    endproperty
    a_scl_fall_high: assert property (p_scl_fall_high)
        else $error("scl fall with internal scl high did not flag arbitration lost");

    property p_early_sda;
        q.start_wait && q.ctrl[2] && mon_bus.sda_fall && int_sda_i |=> status_flags_o[3];
    endproperty
    a_early_sda: assert property (p_early_sda)
        else $error("foreign sda low after start command did not flag arbitration lost");

    property p_data_clear;
        data_clr_w && (set_w[3:1] == 3'h0) |=> (status_flags_o[3:1] == 3'h0);
    endproperty
    a_data_clear: assert property (p_data_clear)
        else $error("data register access did not clear match and arbitration flags");

    property p_arb_read_write_clear;
        (rd_stat_w && q.flags[3]) ##1 (wr_stat_w && !wdata_i[3] && !arb_set_w)
            |=> !status_flags_o[3];
    endproperty
    a_arb_read_write_clear: assert property (p_arb_read_write_clear)
        else $error("read one then write zero did not clear arbitration lost");

    property p_primary_match;
        first_w && !q.prim_addr[0] && (mon_bus.byte_val[7:1] == q.prim_addr[7:1])
            |=> status_flags_o[2];
    endproperty
    a_primary_match: assert property (p_primary_match)
        else $error("primary address match did not set slave match");

    property p_slave_read_write_clear;
        (rd_stat_w && q.flags[2]) ##1 (wr_stat_w && !wdata_i[2] && !slv_set_w)
            |=> !status_flags_o[2];
    endproperty
    a_slave_read_write_clear: assert property (p_slave_read_write_clear)
        else $error("read one then write zero did not clear slave match");

    property p_gcall_set;
        first_w && gc_w && (!q.prim_addr[0] || !q.sec_addr[0]) |=> status_flags_o[1];
    endproperty
    a_gcall_set: assert property (p_gcall_set)
        else $error("general call frame did not set its flag");

    property p_gcall_read_write_clear;
        (rd_stat_w && q.flags[1]) ##1 (wr_stat_w && !wdata_i[1] && !gc_set_w)
            |=> !status_flags_o[1];
    endproperty
    a_gcall_read_write_clear: assert property (p_gcall_read_write_clear)
        else $error("read one then write zero did not clear general call");

    property p_gcall_unrecognized;
        first_w && gc_w && q.prim_addr[0] && !q.sec_addr[0] && !q.flags[2]
            |=> status_flags_o[1] && !status_flags_o[2];
    endproperty
    a_gcall_unrecognized: assert property (p_gcall_unrecognized)
        else $error("general call with primary select one set slave match");

    property p_write_one_keeps;
        wr_stat_w && (wdata_i[4:1] == 4'hf) && !mon_bus.start_det && !data_clr_w
            |=> ((status_flags_o & $past(q.flags)) == $past(q.flags));
    endproperty
    a_write_one_keeps: assert property (p_write_one_keeps)
        else $error("writing one to a flag changed it");

endmodule

// >>> i2c_bus_partner.sv
`timescale 1ns/1ps
module i2c_bus_partner (
    // open-drain pins, enable low while pulling the line low
    output logic scl_oe_n_o,
    output logic sda_oe_n_o
);
    // 96 ns link clock period, clock high for 32 ns
    localparam time HALF = 32;

    // bus idles released, clock stands still outside frames
    initial begin
        scl_oe_n_o = 1'b1;
        sda_oe_n_o = 1'b1;
    end

    // start, eight bits msb first, released ack slot, stop
    task automatic send_frame(input logic [7:0] frame);
        sda_oe_n_o = 1'b0;
        #HALF scl_oe_n_o = 1'b0;
        for (int i = 7; i >= -1; i--) begin
            #HALF sda_oe_n_o = (i < 0) ? 1'b1 : frame[i];
            #HALF scl_oe_n_o = 1'b1;
            #HALF scl_oe_n_o = 1'b0;
        end
        #HALF sda_oe_n_o = 1'b0;
        #HALF scl_oe_n_o = 1'b1;
        #HALF sda_oe_n_o = 1'b1;
        #(2 * HALF);
    endtask

    // one clock pulse, data changed only while the clock is low
    task automatic clock_bit(input logic bit_val);
        #HALF scl_oe_n_o = 1'b0;
        #HALF sda_oe_n_o = bit_val;
        #HALF scl_oe_n_o = 1'b1;
        #HALF scl_oe_n_o = 1'b0;
        #HALF sda_oe_n_o = 1'b1;
        #HALF scl_oe_n_o = 1'b1;
        #(2 * HALF);
    endtask

    // another party grabs the data line while the clock is high
    task automatic pull_sda();
        sda_oe_n_o = 1'b0;
        #(4 * HALF) sda_oe_n_o = 1'b1;
        #(4 * HALF);
    endtask
endmodule

// >>> i2c_addr_match_arb_flags_tb.sv
`timescale 1ns/1ps
module i2c_addr_match_arb_flags_tb;
    localparam logic [7:0] ST = i2c_flags_pkg::OFS_STATUS;
    localparam logic [7:0] PA = i2c_flags_pkg::OFS_PRIM_ADDR;
    localparam logic [7:0] SA = i2c_flags_pkg::OFS_SEC_ADDR;
    localparam logic [7:0] CT = i2c_flags_pkg::OFS_CTRL;
    localparam logic [7:0] DT = i2c_flags_pkg::OFS_DATA;
    localparam logic [7:0] IS = i2c_flags_pkg::OFS_IRQ_STAT;
    localparam logic [7:0] IM = i2c_flags_pkg::OFS_IRQ_MASK;
    logic clk;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic int_sda = 1'b1;
    logic int_scl = 1'b1;
    logic rd_seen = 1'b0;
    logic [7:0] exp_v;
    logic [7:0] exp_q[$];
    logic [6:0] prim;
    logic [6:0] sec;
    logic [7:0] frames[3];
    logic bit_r;
    wire [7:0] rdata;
    wire [7:0] flags;
    wire irq;
    wire scl_oe_n;
    wire sda_oe_n;
    // wired-and of both parties, pull-ups make released lines high
    wire scl_pin = scl_oe_n & int_scl;
    wire sda_pin = sda_oe_n & int_sda;
    int error_cnt = 0;
    int checks_done = 0;

    i2c_addr_match_arb_flags i_dut (
        .core_clk_i(clk),
        .reset_i(rst),
        .addr_i(addr),
        .wdata_i(wdata),
        .wr_i(wr),
        .rd_i(rd),
        .rdata_o(rdata),
        .scl_i(scl_pin),
        .sda_i(sda_pin),
        .int_sda_i(int_sda),
        .int_scl_i(int_scl),
        .status_flags_o(flags),
        .irq_o(irq)
    );

    i2c_bus_partner i_partner (
        .scl_oe_n_o(scl_oe_n),
        .sda_oe_n_o(sda_oe_n)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic conclude();
        if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // expected read data queued for the watcher below
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask

    // read then write in back-to-back cycles
    task automatic rd_wr(input logic [7:0] a, input logic [7:0] e, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic chk_flags(input logic [7:0] e);
        @(negedge clk);
        checks_done++;
        if (flags !== e) begin
            error_cnt++;
            $display("MISMATCH %0t flags %h want %h", $time, flags, e);
        end
    endtask

    task automatic chk_irq(input logic e);
        repeat (3) @(posedge clk);
        @(negedge clk);
        checks_done++;
        if (irq !== e) begin
            error_cnt++;
            $display("MISMATCH %0t irq %b want %b", $time, irq, e);
        end
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge clk) rd_seen <= rd;
    always @(negedge clk) begin
        if (rd_seen) begin
            exp_v = exp_q.pop_front();
            checks_done++;
            if (rdata !== exp_v) begin
                error_cnt++;
                $display("MISMATCH %0t read got %h want %h", $time, rdata, exp_v);
            end
        end
    end

    initial begin
        #200us;
        error_cnt++;
        conclude();
    end

    initial begin
        void'($urandom(66951));
        prim = 7'($urandom_range(62, 1));
        sec = prim | 7'h40;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 8; a++) rd_reg(8'(a), 8'h00);
        wr_reg(PA, {prim, 1'b0});
        wr_reg(SA, {sec, 1'b0});
        rd_reg(PA, {prim, 1'b0});
        // primary address frame, interrupt still masked
        i_partner.send_frame({prim, 1'($urandom)});
        chk_irq(1'b0);
        chk_flags(8'h04);
        wr_reg(ST, 8'h00);
        rd_reg(ST, 8'h04);
        wr_reg(ST, 8'h1e);
        rd_wr(ST, 8'h04, 8'h00);
        rd_reg(ST, 8'h00);
        // second address, cleared by software then by a start
        i_partner.send_frame({sec, 1'($urandom)});
        rd_reg(ST, 8'h10);
        wr_reg(ST, 8'h00);
        rd_reg(ST, 8'h00);
        i_partner.send_frame({sec, 1'b0});
        rd_reg(ST, 8'h10);
        i_partner.send_frame(8'hff);
        rd_reg(ST, 8'h00);
        // sticky event bits, mask and write-one clear
        wr_reg(IM, 8'h10);
        chk_irq(1'b1);
        rd_reg(IS, 8'h14);
        wr_reg(IS, 8'h10);
        chk_irq(1'b0);
        rd_reg(IS, 8'h04);
        rd_reg(IM, 8'h10);
        // general call with both format selects 0, then only the second
        i_partner.send_frame(8'h00);
        rd_reg(ST, 8'h06);
        rd_reg(DT, 8'h00);
        rd_reg(ST, 8'h00);
        wr_reg(PA, {prim, 1'b1});
        i_partner.send_frame(8'h00);
        wr_reg(ST, 8'h00);
        rd_wr(ST, 8'h02, 8'h00);
        rd_reg(ST, 8'h00);
        // no matching with both format selects 1
        wr_reg(SA, {sec, 1'b1});
        frames = '{8'h00, {sec, 1'b0}, {prim, 1'b0}};
        foreach (frames[i]) i_partner.send_frame(frames[i]);
        rd_reg(ST, 8'h00);
        // master transmit, arbitration select 1
        wr_reg(CT, 8'h07);
        rd_reg(CT, 8'h07);
        // our data line agrees with the bus: no loss
        bit_r = 1'($urandom);
        int_sda <= bit_r;
        i_partner.clock_bit(bit_r);
        @(posedge clk);
        int_sda <= 1'b1;
        rd_reg(ST, 8'h00);
        i_partner.clock_bit(1'b0);
        rd_reg(ST, 8'h08);
        wr_reg(DT, 8'h5a);
        rd_reg(ST, 8'h00);
        // arbitration select 0: clock falls while ours is released
        wr_reg(CT, 8'h03);
        // our own clock pulled low: no loss
        int_scl <= 1'b0;
        repeat (8) @(posedge clk);
        int_scl <= 1'b1;
        repeat (4) @(posedge clk);
        rd_reg(ST, 8'h00);
        i_partner.clock_bit(1'b1);
        rd_wr(ST, 8'h08, 8'h00);
        rd_reg(ST, 8'h00);
        // start command pending, other party pulls data low first
        // we drive data low first: the early check stands down
        wr_reg(CT, 8'h0f);
        int_sda <= 1'b0;
        repeat (8) @(posedge clk);
        int_sda <= 1'b1;
        repeat (8) @(posedge clk);
        i_partner.pull_sda();
        rd_reg(ST, 8'h00);
        wr_reg(CT, 8'h0f);
        i_partner.pull_sda();
        rd_reg(ST, 8'h08);
        chk_flags(8'h08);
        repeat (4) @(posedge clk);
        conclude();
    end
endmodule
